/* File: rtl/sfc_pkg.sv */
// package: constants and carrier types for the sar adc serial frame control
package sfc_pkg;

    // ----------------------------------------
    // converter shape
    // ----------------------------------------
    localparam int unsigned RES_BITS = 8;
    localparam logic [7:0]  SAR_MSB  = 8'h80;
    localparam logic [7:0]  CODE_MAX = 8'hFF;
    localparam logic [7:0]  STORE_RST = 8'h00;

    // ----------------------------------------
    // frame edge numbers (sclk falling edges)
    // ----------------------------------------
    localparam logic [5:0] EDGE_LEAD_LAST = 6'h02;
    localparam logic [5:0] EDGE_LAST_BIT  = 6'h0A;
    localparam logic [5:0] EDGE_PCAL_DONE = 6'h10;
    localparam logic [5:0] EDGE_CAL_START = 6'h11;
    localparam logic [5:0] EDGE_CAL_DONE  = 6'h20;
    localparam logic [5:0] EDGE_MAX       = 6'h3F;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned ACQUISITION_INTERVAL_NS = 275;
    localparam int unsigned ACQ_CYCLES =
        (ACQUISITION_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0]  ACQ_CNT = 6'(ACQ_CYCLES);

    // ----------------------------------------
    // carrier towards the analog sampling stage
    // ----------------------------------------
    typedef struct packed {
        logic       connect;  // sampling caps tied to the analog inputs
        logic       zero_in;  // inputs shorted for offset measurement
        logic       capture;  // one-cycle pulse: open switch, hold sample
        logic [7:0] dac;      // trial code driven to the cap dac
    } sfc_ana_s;

    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_CONV,
        SFC_SHIFT,
        SFC_CAL
    } sfc_state_e;

endpackage

/* File: rtl/sfc_sar.sv */
// successive approximation register stepping one bit per step pulse
`timescale 1ns/1ps
module sfc_sar
    import sfc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       step,
    input  wire logic       cmp_hi,
    output logic [7:0]      code,
    output logic            busy,
    output logic            done
);

    logic [7:0] mask;
    wire  [7:0] keep      = cmp_hi ? code : (code & ~mask);
    wire  [7:0] next_mask = mask >> 1;
    wire        do_step   = step && busy && !start;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code <= 8'h00;
            mask <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= do_step && (next_mask == 8'h00);
            if (start) begin
                code <= SAR_MSB;
                mask <= SAR_MSB;
            end else if (do_step) begin
                code <= keep | next_mask;
                mask <= next_mask;
            end
        end
    end

    assign busy = (mask != 8'h00);

endmodule

/* File: rtl/sfc_frame.sv */
// conversion frame control: sampling, sar timing, serial out, offset calibration
//
// Contract
// - the falling edge of chip select captures the input difference and starts its conversion.
// - the serial clock alone steps the conversion and the output shift.
// - inputs stay isolated during conversion and reconnect for acquisition once it ends.
// - conversion ends within eight and a half serial clocks after the select setup.
// - offset calibration runs in the first frame after power-up or in any later long frame.
// - results are unsigned straight binary, zero at the bottom and all ones at the top.
// - one code step is the supply reference divided by two to the resolution.
// - each frame after the power-up frame shifts two zeros then eight result bits msb first, last bit on the 10th falling edge.
// - data stays low after the 10th edge and is released when chip select rises.
// - the first frame after power-up calibrates with data low and commits only after 16 edges.
// - in normal frames calibration runs from edge 17 to edge 32 and shorter frames keep the old correction.
`timescale 1ns/1ps
module sfc_frame
    import sfc_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic cmp_hi,
    output logic      sdo_o,
    output logic      sdo_oe,
    output sfc_ana_s  ana,
    output logic      acq_ok,
    output logic      conv_done
);

    // ----------------------------------------
    // pin edges
    // ----------------------------------------
    logic cs_q;
    logic sclk_q;
    wire  cs_fall   = cs_q && !cs_n;
    wire  cs_rise   = !cs_q && cs_n;
    wire  sclk_fall = sclk_q && !sclk && !cs_n;

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    sfc_state_e state;
    sfc_state_e next_state;
    logic [5:0] edge_cnt;
    logic       first_frame;
    logic       pwr_cal;
    logic [7:0] offset_correction_store;
    logic [7:0] cal_code;
    logic       cal_valid;
    logic [5:0] acq_cnt;

    wire [5:0] next_cnt = (edge_cnt == EDGE_MAX) ? EDGE_MAX : edge_cnt + 6'h01;

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? CODE_MAX : s[7:0];
    endfunction

    // ----------------------------------------
    // sar core
    // ----------------------------------------
    logic [7:0] sar_code;
    logic       sar_busy;
    logic       sar_done;
    wire        norm_cal_go = sclk_fall && !pwr_cal && (next_cnt == EDGE_CAL_START);
    wire        sar_start   = cs_fall || norm_cal_go;
    wire        cal_active  = (state == SFC_CAL);

    sfc_sar u_sar (
        .clk    (clk),
        .nrst   (nrst),
        .start  (sar_start),
        .step   (sclk_fall),
        .cmp_hi (cmp_hi),
        .code   (sar_code),
        .busy   (sar_busy),
        .done   (sar_done)
    );

    // ----------------------------------------
    // state walk
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SFC_IDLE:  if (cs_fall) next_state = first_frame ? SFC_CAL : SFC_CONV;
            SFC_CONV:  if (cs_rise) next_state = SFC_IDLE;
                       else if (sar_done) next_state = SFC_SHIFT;
            SFC_SHIFT: if (cs_rise) next_state = SFC_IDLE;
                       else if (norm_cal_go) next_state = SFC_CAL;
            SFC_CAL:   if (cs_rise) next_state = SFC_IDLE;
            default:   next_state = SFC_IDLE;
        endcase
    end

    // result bit for the edge about to happen: zeros first, then msb down
    wire       in_data  = (next_cnt > EDGE_LEAD_LAST) && (next_cnt <= EDGE_LAST_BIT);
    wire [2:0] bit_sel  = 3'(EDGE_LAST_BIT - next_cnt);
    wire       next_sdo = !pwr_cal && in_data && sar_code[bit_sel];
    wire       commit   = sclk_fall && cal_valid &&
                          (next_cnt == (pwr_cal ? EDGE_PCAL_DONE : EDGE_CAL_DONE));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_q   <= 1'b1;
            sclk_q <= 1'b0;
            state  <= SFC_IDLE;
        end else begin
            cs_q   <= cs_n;
            sclk_q <= sclk;
            state  <= next_state;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            edge_cnt <= 6'h00;
            sdo_o    <= 1'b0;
        end else if (cs_n || cs_fall) begin
            edge_cnt <= 6'h00;
            sdo_o    <= 1'b0;
        end else if (sclk_fall) begin
            edge_cnt <= next_cnt;
            sdo_o    <= next_sdo;
        end
    end

    // power-up is the only reset, so first_frame marks the power-up frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_frame <= 1'b1;
            pwr_cal     <= 1'b0;
        end else if (cs_fall) begin
            first_frame <= 1'b0;
            pwr_cal     <= first_frame;
        end else if (cs_rise) begin
            pwr_cal     <= 1'b0;
        end
    end

    // a measured code only lands in the store on the commit edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset_correction_store <= STORE_RST;
            cal_code  <= 8'h00;
            cal_valid <= 1'b0;
        end else begin
            if (sar_start || cs_rise)
                cal_valid <= 1'b0;
            else if (sar_done && cal_active) begin
                cal_code  <= sar_code;
                cal_valid <= 1'b1;
            end
            if (commit)
                offset_correction_store <= cal_code;
        end
    end

    // ----------------------------------------
    // analog stage
    // ----------------------------------------
    // offset is folded into the dac trial so each bit is final when decided;
    // only a positive offset is corrected, the dac saturates at full scale
    wire isolate = (state == SFC_CONV) || cal_active || cs_fall;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ana       <= '{connect: 1'b1, zero_in: 1'b0, capture: 1'b0, dac: 8'h00};
            conv_done <= 1'b0;
            acq_cnt   <= 6'h00;
            acq_ok    <= 1'b0;
        end else begin
            ana.connect <= !isolate;
            ana.zero_in <= cal_active;
            ana.capture <= cs_fall;
            ana.dac     <= cal_active ? sar_code : sat_add(sar_code, offset_correction_store);
            conv_done   <= sar_done && (state == SFC_CONV);
            if (isolate)
                acq_cnt <= 6'h00;
            else if (acq_cnt != ACQ_CNT)
                acq_cnt <= acq_cnt + 6'h01;
            acq_ok      <= !isolate && (acq_cnt == ACQ_CNT);
        end
    end

    assign sdo_oe = !cs_n;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_cnt_clear: assert property (cs_n |=> edge_cnt == 6'h00)
        else $error("edge count not cleared while deselected");
    chk_sdo_release: assert property (cs_n && $past(cs_n) |-> !sdo_oe && !sdo_o)
        else $error("data not released while deselected");
    chk_sdo_tail: assert property (edge_cnt > EDGE_LAST_BIT |-> !sdo_o)
        else $error("data not low after last bit");
    chk_lead_zero: assert property (!cs_n && edge_cnt <= EDGE_LEAD_LAST |-> !sdo_o)
        else $error("leading bits not zero");
    chk_pcal_low: assert property (pwr_cal |-> !sdo_o)
        else $error("data not low in power-up frame");
    chk_capture: assert property (cs_fall |=> ana.capture ##1 !ana.capture)
        else $error("sample capture pulse wrong");
    chk_isolate: assert property (state == SFC_CONV |=> !ana.connect)
        else $error("inputs connected during conversion");
    // the sar done pulse is registered, so the state moves two clocks after the eighth edge
    chk_conv_end: assert property (state == SFC_CONV && sclk_fall && edge_cnt == 6'(RES_BITS - 1)
                                   |-> ##2 (state == SFC_SHIFT || cs_n))
        else $error("conversion not done on eighth edge");
    chk_store_hold: assert property (!commit |=> $stable(offset_correction_store))
        else $error("offset store changed without commit");
    chk_step_clk: assert property (!sclk_fall && !sar_start |=> $stable(sar_code))
        else $error("sar moved without serial clock");

    cov_conv:  cover property (conv_done);
    cov_pcal:  cover property (commit && pwr_cal);
    cov_ncal:  cover property (commit && !pwr_cal);
    cov_short: cover property (cal_active && cs_rise && !cal_valid);

endmodule

/* File: tb/sfc_ana_model.sv */
// analog stage model: sample hold and comparator facing the frame control
`timescale 1ns/1ps
module sfc_ana_model
    import sfc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire sfc_ana_s   ana,
    input  wire logic [7:0] vin,
    input  wire logic [7:0] off,
    output logic            cmp_hi
);
    // ----------------------------------------
    // held sample in code steps, offset added
    // ----------------------------------------
    // nine bits so that a large offset can push past full scale
    logic [8:0] held;
    logic [8:0] level;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            held <= 9'h000;
        end else if (ana.capture) begin
            held <= {1'b0, vin} + {1'b0, off};
        end
    end
    // shorted inputs leave only the offset on the caps
    assign level  = ana.zero_in ? {1'b0, off} : held;
    assign cmp_hi = (level >= {1'b0, ana.dac});
endmodule

/* File: tb/sfc_frame_bench.sv */
// bench: frame control driven as a serial host, with the analog model
`timescale 1ns/1ps
module sfc_frame_bench
    import sfc_pkg::*;
;
    logic       clk  = 1'b0;
    logic       nrst = 1'b0;
    logic       cs_n = 1'b1;
    logic       sclk = 1'b1;
    logic [7:0] vin  = 8'h00;
    logic [7:0] off  = 8'h00;
    logic [9:0] b;
    wire logic  cmp_hi;
    wire logic  sdo_o;
    wire logic  sdo_oe;
    wire logic  acq_ok;
    wire logic  conv_done;
    sfc_ana_s   ana;
    int         num_errors = 0;
    int         checks     = 0;
    int         cyc        = 0;
    int         cd_at      = 0;

    sfc_frame u_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .cmp_hi(cmp_hi),
                     .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ana(ana), .acq_ok(acq_ok), .conv_done(conv_done));
    sfc_ana_model u_ana (.clk(clk), .nrst(nrst), .ana(ana), .vin(vin), .off(off), .cmp_hi(cmp_hi));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cs_n ? 0 : cyc + 1;
        if (!cs_n && cyc == 0) begin
            cd_at <= 0;
        end else if (conv_done && cd_at == 0) begin
            cd_at <= cyc;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic test_done;
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            $display("[FAIL] %0t %s", $time, m);
            num_errors++;
        end
    endtask
    task automatic rst;
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
    endtask
    // sclk phases of five clocks: 10 MHz, under the host ceiling
    task automatic frame(input int n, output logic [9:0] r);
        r = 10'h000;
        @(negedge clk) cs_n = 1'b0;
        repeat (2) @(negedge clk);
        for (int k = 1; k <= n; k++) begin
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            if (k <= 10) begin
                r = {r[8:0], sdo_o};
            end else begin
                chk(sdo_o === 1'b0, "sdo not low after edge ten");
            end
            if (k == 4) begin
                chk(ana.connect === 1'b0 && sdo_oe === 1'b1, "inputs not isolated");
            end
            @(negedge clk) sclk = 1'b1;
            repeat (5) @(negedge clk);
        end
        cs_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(sdo_oe === 1'b0 && sdo_o === 1'b0, "sdo not released");
        repeat (30) @(negedge clk);
        chk(ana.connect === 1'b1 && acq_ok === 1'b1, "no acquisition");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_powerup;
        rst();
        off = 8'h03;
        vin = 8'h55;
        frame(16, b);
        chk(b === 10'h000, "power-up frame not low");
        frame(10, b);
        chk(b === {2'b00, 8'h55}, "offset not removed");
    endtask
    task automatic t_codes;
        logic [7:0] tbl [6];
        tbl = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hFF, 8'hA5};
        foreach (tbl[i]) begin
            vin = tbl[i];
            frame(12, b);
            chk(b === {2'b00, tbl[i]}, "wrong code");
            chk(cd_at > 0 && cd_at <= 87, "conversion too slow");
        end
    endtask
    task automatic t_short_cal;
        rst();
        off = 8'h03;
        frame(10, b);
        chk(b === 10'h000, "short power-up frame not low");
        vin = 8'h40;
        frame(10, b);
        chk(b === {2'b00, 8'h43}, "store changed by short frame");
    endtask
    task automatic t_normal_cal;
        vin = 8'h20;
        frame(32, b);
        chk(b === {2'b00, 8'h23}, "long frame code");
        frame(10, b);
        chk(b === {2'b00, 8'h20}, "calibration not stored");
        off = 8'h06;
        frame(31, b);
        frame(10, b);
        chk(b === {2'b00, 8'h23}, "store changed by 31 edges");
        frame(5, b);
        frame(20, b);
        frame(10, b);
        chk(b === {2'b00, 8'h23}, "store changed by cut frames");
        frame(32, b);
        frame(10, b);
        chk(b === {2'b00, 8'h20}, "recalibration failed");
    endtask

    initial begin
        #200us;
        num_errors++;
        test_done();
    end
    initial begin
        t_powerup();
        t_codes();
        t_short_cal();
        t_normal_cal();
        test_done();
    end
endmodule
